// ===== logic/gesture_fifo_control.sv
// gesture host interface: control, level, flags, fifo ports, interrupt clears
// Notes on behaviour
// - gesture irq enable set unmasks gesture interrupt sources; clear keeps them masked.
// - run bit reads 1 while gesture engine runs, else 0.
// - writing 1 to run bit enters gesture operation at once.
// - writing 0 leaves gesture operation after current conversion finishes.
// - read-only level register counts complete datasets waiting in fifo.
// - east port access pops one dataset and decrements level.
// - overflow flag sets when full fifo discards a new dataset.
// - valid flag sets when level exceeds threshold; gesture irq condition too.
// - valid flag clears only when run bit is 0 and level zero.
// - fifo holds 32 four-byte north south west east datasets.
// - a 33rd dataset is discarded, stored ones kept, overflow raised.
// - north, south, west, east bytes of oldest dataset on four ports.
// - single-byte or page reads both accepted.
// - reads with level zero return zero bytes.
// - any access to a clear register clears its interrupt source.
// - access to force register asserts interrupt pin regardless of sources.
// - gesture irq stays while level above threshold, independent of valid flag.
`timescale 1ns/1ps
`default_nettype none
module gesture_fifo_control #(
    parameter int DEPTH = gesture_fifo_pkg::FIFO_DEPTH
) (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire gesture_fifo_pkg::reg_req_s reg_req,
    output logic [7:0]                      reg_rdata,
    input  wire logic [7:0]                 fifo_threshold,
    input  wire logic                       entry_threshold_hit,
    input  wire logic                       exit_threshold_hit,
    input  wire logic                       conversion_done,
    input  wire logic                       dataset_push,
    input  wire gesture_fifo_pkg::dataset_s dataset_data,
    input  wire logic                       pattern_burst_event,
    input  wire logic                       proximity_event,
    input  wire logic                       light_event,
    output logic                            gesture_run,
    output logic                            gesture_irq,
    output logic                            irq_out
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    gesture_fifo_pkg::run_state_e            run_state_r;
    gesture_fifo_pkg::run_state_e            run_state_nxt;
    gesture_fifo_pkg::dataset_s              head;
    logic [gesture_fifo_pkg::LVL_W-1:0]      level;
    logic                                    dropped;
    logic                                    irq_enable_r;
    logic                                    overflow_flag_r;
    logic                                    valid_flag_r;
    logic                                    force_r;
    logic                                    pb_pend_r;
    logic                                    prox_pend_r;
    logic                                    light_pend_r;
    logic                                    acc;
    logic                                    wr_ctrl;
    logic                                    pop;
    logic                                    above_th;
    logic                                    run_bit;
    logic [7:0]                              rdata_nxt;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    assign acc      = reg_req.rd || reg_req.wr;
    assign wr_ctrl  = reg_req.wr && hit(reg_req.addr, gesture_fifo_pkg::ADDR_GESTURE_CONTROL);
    assign pop      = acc && hit(reg_req.addr, gesture_fifo_pkg::ADDR_EAST_PORT);
    assign above_th = ({2'b00, level} > fifo_threshold);
    assign run_bit  = (run_state_r != gesture_fifo_pkg::ST_IDLE);

    // ------------------------------------------------------------
    // dataset storage
    // ------------------------------------------------------------
    dataset_store #(
        .DEPTH     (DEPTH)
    ) u_store (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .push      (dataset_push && run_bit),
        .push_data (dataset_data),
        .pop       (pop),
        .head      (head),
        .level     (level),
        .dropped   (dropped)
    );

    // ------------------------------------------------------------
    // gesture run state
    // ------------------------------------------------------------
    always_comb begin
        run_state_nxt = run_state_r;
        unique case (run_state_r)
            gesture_fifo_pkg::ST_IDLE: begin
                if ((wr_ctrl && reg_req.wdata[gesture_fifo_pkg::RUN_BIT]) || entry_threshold_hit) begin
                    run_state_nxt = gesture_fifo_pkg::ST_RUN;
                end
            end
            gesture_fifo_pkg::ST_RUN: begin
                if ((wr_ctrl && !reg_req.wdata[gesture_fifo_pkg::RUN_BIT]) || exit_threshold_hit) begin
                    run_state_nxt = conversion_done ? gesture_fifo_pkg::ST_IDLE
                                                    : gesture_fifo_pkg::ST_EXITING;
                end
            end
            gesture_fifo_pkg::ST_EXITING: begin
                if (wr_ctrl && reg_req.wdata[gesture_fifo_pkg::RUN_BIT]) begin
                    run_state_nxt = gesture_fifo_pkg::ST_RUN;
                end else if (conversion_done) begin
                    run_state_nxt = gesture_fifo_pkg::ST_IDLE;
                end
            end
            default: run_state_nxt = gesture_fifo_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_state_r <= gesture_fifo_pkg::ST_IDLE;
        end else begin
            run_state_r <= run_state_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            irq_enable_r <= reg_req.wdata[gesture_fifo_pkg::IRQ_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            overflow_flag_r <= 1'b0;
        end else if (dropped) begin
            overflow_flag_r <= 1'b1;
        end else if (!run_bit && level == '0) begin
            overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            valid_flag_r <= 1'b0;
        end else if (above_th) begin
            valid_flag_r <= 1'b1;
        end else if (!run_bit && level == '0) begin
            valid_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt sources, clears and force
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pb_pend_r    <= 1'b0;
            prox_pend_r  <= 1'b0;
            light_pend_r <= 1'b0;
        end else begin
            if (pattern_burst_event) begin
                pb_pend_r <= 1'b1;
            end else if (acc && (hit(reg_req.addr, gesture_fifo_pkg::ADDR_PB_CLEAR)
                                 || hit(reg_req.addr, gesture_fifo_pkg::ADDR_ALL_CLEAR))) begin
                pb_pend_r <= 1'b0;
            end
            if (proximity_event) begin
                prox_pend_r <= 1'b1;
            end else if (acc && (hit(reg_req.addr, gesture_fifo_pkg::ADDR_PROX_CLEAR)
                                 || hit(reg_req.addr, gesture_fifo_pkg::ADDR_ALL_CLEAR))) begin
                prox_pend_r <= 1'b0;
            end
            if (light_event) begin
                light_pend_r <= 1'b1;
            end else if (acc && (hit(reg_req.addr, gesture_fifo_pkg::ADDR_LIGHT_CLEAR)
                                 || hit(reg_req.addr, gesture_fifo_pkg::ADDR_ALL_CLEAR))) begin
                light_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            force_r <= 1'b0;
        end else if (acc && hit(reg_req.addr, gesture_fifo_pkg::ADDR_IRQ_FORCE)) begin
            force_r <= 1'b1;
        end else if (acc && hit(reg_req.addr, gesture_fifo_pkg::ADDR_ALL_CLEAR)) begin
            force_r <= 1'b0;
        end
    end

    assign gesture_irq = irq_enable_r && above_th;
    assign irq_out     = gesture_irq || force_r || pb_pend_r || prox_pend_r || light_pend_r;
    assign gesture_run = run_bit;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = gesture_fifo_pkg::RESET_BYTE;
        unique case (reg_req.addr)
            gesture_fifo_pkg::ADDR_GESTURE_CONTROL: begin
                rdata_nxt[gesture_fifo_pkg::IRQ_EN_BIT] = irq_enable_r;
                rdata_nxt[gesture_fifo_pkg::RUN_BIT]    = run_bit;
            end
            gesture_fifo_pkg::ADDR_FIFO_LEVEL:  rdata_nxt = {2'b00, level};
            gesture_fifo_pkg::ADDR_STATE_FLAGS: begin
                rdata_nxt[gesture_fifo_pkg::OVERFLOW_BIT] = overflow_flag_r;
                rdata_nxt[gesture_fifo_pkg::VALID_BIT]    = valid_flag_r;
            end
            gesture_fifo_pkg::ADDR_NORTH_PORT: rdata_nxt = head.north;
            gesture_fifo_pkg::ADDR_SOUTH_PORT: rdata_nxt = head.south;
            gesture_fifo_pkg::ADDR_WEST_PORT:  rdata_nxt = head.west;
            gesture_fifo_pkg::ADDR_EAST_PORT:  rdata_nxt = head.east;
            default:                           rdata_nxt = gesture_fifo_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= gesture_fifo_pkg::RESET_BYTE;
        end else if (reg_req.rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_irq_mask;
        @(posedge core_clk) disable iff (sys_rst)
        !irq_enable_r |-> !gesture_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("gesture irq while masked");

    property p_enter;
        @(posedge core_clk) disable iff (sys_rst)
        (wr_ctrl && reg_req.wdata[gesture_fifo_pkg::RUN_BIT]) |=> gesture_run;
    endproperty
    a_enter: assert property (p_enter) else $error("run bit write did not enter");

    property p_exit_wait;
        @(posedge core_clk) disable iff (sys_rst)
        (run_state_r == gesture_fifo_pkg::ST_EXITING && !conversion_done && !wr_ctrl) |=> gesture_run;
    endproperty
    a_exit_wait: assert property (p_exit_wait) else $error("left before conversion end");

    property p_pop;
        @(posedge core_clk) disable iff (sys_rst)
        (pop && level != '0 && !(dataset_push && run_bit)) |=> (level == $past(level) - 1'b1);
    endproperty
    a_pop: assert property (p_pop) else $error("east access did not pop");

    property p_ovf;
        @(posedge core_clk) disable iff (sys_rst)
        dropped |=> overflow_flag_r;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_valid;
        @(posedge core_clk) disable iff (sys_rst)
        above_th |=> valid_flag_r;
    endproperty
    a_valid: assert property (p_valid) else $error("valid not set");

    property p_valid_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (valid_flag_r && (run_bit || level != '0)) |=> valid_flag_r;
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("valid cleared early");

    property p_empty_zero;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == gesture_fifo_pkg::ADDR_EAST_PORT && level == '0) |=> reg_rdata == '0;
    endproperty
    a_empty_zero: assert property (p_empty_zero) else $error("empty fifo read nonzero");

    property p_force;
        @(posedge core_clk) disable iff (sys_rst)
        (acc && reg_req.addr == gesture_fifo_pkg::ADDR_IRQ_FORCE) |=> irq_out;
    endproperty
    a_force: assert property (p_force) else $error("force did not raise pin");

    property p_run_read;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == gesture_fifo_pkg::ADDR_GESTURE_CONTROL)
            |=> reg_rdata[gesture_fifo_pkg::RUN_BIT] == $past(run_bit);
    endproperty
    a_run_read: assert property (p_run_read) else $error("run bit read back wrong");

    property p_level_read;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == gesture_fifo_pkg::ADDR_FIFO_LEVEL) |=> reg_rdata == {2'b00, $past(level)};
    endproperty
    a_level_read: assert property (p_level_read) else $error("level read back wrong");

    property p_valid_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (!run_bit && level == '0) |=> !valid_flag_r;
    endproperty
    a_valid_clear: assert property (p_valid_clear) else $error("valid not cleared when drained");

    property p_clear_all;
        @(posedge core_clk) disable iff (sys_rst)
        (acc && reg_req.addr == gesture_fifo_pkg::ADDR_ALL_CLEAR && !pattern_burst_event) |=> !pb_pend_r;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("all clear left source pending");

    property p_north;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == gesture_fifo_pkg::ADDR_NORTH_PORT) |=> reg_rdata == $past(head.north);
    endproperty
    a_north: assert property (p_north) else $error("north port not oldest dataset");

    property p_entry_pin;
        @(posedge core_clk) disable iff (sys_rst)
        (run_state_r == gesture_fifo_pkg::ST_IDLE && entry_threshold_hit) |=> gesture_run;
    endproperty
    a_entry_pin: assert property (p_entry_pin) else $error("entry threshold did not enter");

    property p_exit_pin;
        @(posedge core_clk) disable iff (sys_rst)
        (run_state_r == gesture_fifo_pkg::ST_RUN && exit_threshold_hit && conversion_done) |=> !gesture_run;
    endproperty
    a_exit_pin: assert property (p_exit_pin) else $error("exit with conversion end stayed");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_force:    cover property (@(posedge core_clk) disable iff (sys_rst)
                                acc && reg_req.addr == gesture_fifo_pkg::ADDR_IRQ_FORCE);
    c_drain:    cover property (@(posedge core_clk) disable iff (sys_rst) pop && level == '0);
    c_overflow: cover property (@(posedge core_clk) disable iff (sys_rst) dropped);
    c_irq:      cover property (@(posedge core_clk) disable iff (sys_rst) gesture_irq);
    c_exit:     cover property (@(posedge core_clk) disable iff (sys_rst)
                                run_state_r == gesture_fifo_pkg::ST_EXITING ##1 !gesture_run);
endmodule : gesture_fifo_control
`default_nettype wire

// ===== shared/gesture_fifo_pkg.sv
// shared constants and types for the gesture fifo control block
package gesture_fifo_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_GESTURE_CONTROL  = 8'hAB;
    localparam logic [7:0] ADDR_FIFO_LEVEL       = 8'hAE;
    localparam logic [7:0] ADDR_STATE_FLAGS      = 8'hAF;
    localparam logic [7:0] ADDR_PB_CLEAR         = 8'hE3;
    localparam logic [7:0] ADDR_IRQ_FORCE        = 8'hE4;
    localparam logic [7:0] ADDR_PROX_CLEAR       = 8'hE5;
    localparam logic [7:0] ADDR_LIGHT_CLEAR      = 8'hE6;
    localparam logic [7:0] ADDR_ALL_CLEAR        = 8'hE7;
    localparam logic [7:0] ADDR_NORTH_PORT       = 8'hFC;
    localparam logic [7:0] ADDR_SOUTH_PORT       = 8'hFD;
    localparam logic [7:0] ADDR_WEST_PORT        = 8'hFE;
    localparam logic [7:0] ADDR_EAST_PORT        = 8'hFF;
    // ------------------------------------------------------------
    // field positions and sizes
    // ------------------------------------------------------------
    localparam int         RUN_BIT               = 0;
    localparam int         IRQ_EN_BIT            = 1;
    localparam int         VALID_BIT             = 0;
    localparam int         OVERFLOW_BIT          = 1;
    localparam int         FIFO_DEPTH            = 32;
    localparam int         PTR_W                 = 5;
    localparam int         LVL_W                 = 6;
    localparam logic [7:0] RESET_BYTE            = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RUN     = 2'b01,
        ST_EXITING = 2'b10
    } run_state_e;

    // one north/south/west/east dataset
    typedef struct packed {
        logic [7:0] north;
        logic [7:0] south;
        logic [7:0] west;
        logic [7:0] east;
    } dataset_s;

    // host register access
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage : gesture_fifo_pkg

// ===== logic/dataset_store.sv
// dataset memory with wrapping pointers and saturating level
`timescale 1ns/1ps
`default_nettype none
module dataset_store #(
    parameter int DEPTH = gesture_fifo_pkg::FIFO_DEPTH
) (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          push,
    input  wire gesture_fifo_pkg::dataset_s    push_data,
    input  wire logic                          pop,
    output gesture_fifo_pkg::dataset_s         head,
    output logic [gesture_fifo_pkg::LVL_W-1:0] level,
    output logic                               dropped
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    gesture_fifo_pkg::dataset_s                mem [DEPTH];
    logic [gesture_fifo_pkg::PTR_W-1:0]        wr_ptr_r;
    logic [gesture_fifo_pkg::PTR_W-1:0]        rd_ptr_r;
    logic [gesture_fifo_pkg::LVL_W-1:0]        level_r;
    logic                                      full;
    logic                                      empty;
    logic                                      do_push;
    logic                                      do_pop;

    assign full    = (level_r == gesture_fifo_pkg::LVL_W'(DEPTH));
    assign empty   = (level_r == '0);
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign dropped = push && full;
    assign level   = level_r;
    assign head    = empty ? '0 : mem[rd_ptr_r];

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_r <= '0;
        end else if (do_push && !do_pop) begin
            level_r <= level_r + 1'b1;
        end else if (do_pop && !do_push) begin
            level_r <= level_r - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_level_cap;
        @(posedge core_clk) disable iff (sys_rst)
        level_r <= gesture_fifo_pkg::LVL_W'(DEPTH);
    endproperty
    a_level_cap: assert property (p_level_cap) else $error("level above depth");

    property p_full_drop;
        @(posedge core_clk) disable iff (sys_rst)
        (full && push && !pop) |=> $stable(level_r) && $stable(wr_ptr_r);
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("full fifo accepted data");
endmodule : dataset_store
`default_nettype wire

// ===== sim/host_model.sv
// host model issuing byte register accesses to the gesture block
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                      core_clk,
    input  wire logic [7:0]                reg_rdata,
    output var gesture_fifo_pkg::reg_req_s reg_req
);
    // ----------------
    // single byte access
    // ----------------
    initial reg_req = '0;
    task automatic acc(input logic r, input logic w, input logic [7:0] a,
                       input logic [7:0] wd, output logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{rd: r, wr: w, addr: a, wdata: wd & 8'h03};
        @(posedge core_clk);
        reg_req <= '0;
        @(posedge core_clk);
        #1 d = reg_rdata;
    endtask : acc
    // ----------------
    // page read from the north port
    // ----------------
    task automatic page_rd(input int n, ref logic [7:0] q[$]);
        @(posedge core_clk);
        reg_req <= '{rd: 1'b1, wr: 1'b0, addr: 8'hFC, wdata: 8'h00};
        for (int i = 1; i <= n; i++) begin
            @(posedge core_clk);
            if (i == n) reg_req <= '0;
            else reg_req <= '{rd: 1'b1, wr: 1'b0, addr: {6'h3F, i[1:0]}, wdata: 8'h00};
            #1 q.push_back(reg_rdata);
        end
    endtask : page_rd
endmodule : host_model
`default_nettype wire

// ===== sim/gesture_fifo_control_bench.sv
// self-checking bench for the gesture fifo control block
`timescale 1ns/1ps
`default_nettype none
module gesture_fifo_control_bench;
    logic                       core_clk, sys_rst, push_s;
    logic [5:0]                 evt;
    logic [7:0]                 thr, d;
    gesture_fifo_pkg::dataset_s ds;
    gesture_fifo_pkg::reg_req_s reg_req;
    logic [7:0]                 reg_rdata, got[$];
    logic                       gesture_run, gesture_irq, irq_out, ovf;
    gesture_fifo_pkg::dataset_s exp_q[$];
    int                         err_count, checked, seed;
    host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
    gesture_fifo_control DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .fifo_threshold(thr), .entry_threshold_hit(evt[3]), .exit_threshold_hit(evt[4]),
        .conversion_done(evt[5]), .dataset_push(push_s), .dataset_data(ds),
        .pattern_burst_event(evt[0]), .proximity_event(evt[1]), .light_event(evt[2]),
        .gesture_run(gesture_run), .gesture_irq(gesture_irq), .irq_out(irq_out));
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic push(input gesture_fifo_pkg::dataset_s v);
        @(posedge core_clk);
        push_s <= 1'b1;
        ds <= v;
        @(posedge core_clk);
        push_s <= 1'b0;
        #1;
    endtask : push
    task automatic ev(input logic [5:0] m);
        @(posedge core_clk);
        evt <= m;
        @(posedge core_clk);
        evt <= 6'h00;
        #1;
    endtask : ev
    // ----------------
    // clock, watchdog, sequence
    // ----------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #2000000;
        err_count++;
        summarize();
    end
    initial begin
        {sys_rst, push_s, evt, thr, ds, ovf, seed} = {1'b1, 48'h0, 32'd5};
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        thr <= 8'($random(seed) & 7);
        host.acc(1, 0, gesture_fifo_pkg::ADDR_FIFO_LEVEL, 0, d);
        chk("level", 8'h00, d);
        host.acc(1, 0, gesture_fifo_pkg::ADDR_STATE_FLAGS, 0, d);
        chk("flags", 8'h00, d);
        push(32'($random(seed)));
        host.acc(1, 0, gesture_fifo_pkg::ADDR_GESTURE_CONTROL, 0, d);
        chk("control", 8'h00, d);
        host.acc(0, 1, gesture_fifo_pkg::ADDR_GESTURE_CONTROL, 8'h03, d);
        chk("run", 8'h01, 8'(gesture_run));
        for (int i = 0; i < 33; i++) begin
            push(32'($random(seed)));
            if (exp_q.size() < 32) exp_q.push_back(ds);
            else ovf = 1'b1;
            chk("gesture_irq", 8'(exp_q.size() > int'(thr)), 8'(gesture_irq));
        end
        host.acc(1, 0, gesture_fifo_pkg::ADDR_FIFO_LEVEL, 0, d);
        chk("level", 8'h20, d);
        host.acc(1, 0, gesture_fifo_pkg::ADDR_STATE_FLAGS, 0, d);
        chk("flags", {6'h00, ovf, 1'b1}, d);
        for (int b = 0; b < 4; b++) begin
            host.acc(1, 0, 8'hFC + 8'(b), 0, d);
            chk("port", exp_q[0][31-8*b -: 8], d);
        end
        void'(exp_q.pop_front());
        host.acc(1, 0, gesture_fifo_pkg::ADDR_FIFO_LEVEL, 0, d);
        chk("level", 8'h1F, d);
        host.acc(0, 1, gesture_fifo_pkg::ADDR_GESTURE_CONTROL, 8'h01, d);
        chk("masked", 8'h00, 8'(gesture_irq));
        host.acc(0, 1, gesture_fifo_pkg::ADDR_GESTURE_CONTROL, 8'h03, d);
        host.page_rd(4 * exp_q.size() + 4, got);
        for (int j = 0; j < got.size(); j++)
            chk("page", (j / 4 < exp_q.size()) ? exp_q[j/4][31-8*(j%4) -: 8] : 8'h00, got[j]);
        host.acc(1, 0, gesture_fifo_pkg::ADDR_STATE_FLAGS, 0, d);
        chk("valid", 8'h01, d & 8'h01);
        host.acc(0, 1, gesture_fifo_pkg::ADDR_GESTURE_CONTROL, 8'h02, d);
        chk("run", 8'h01, 8'(gesture_run));
        ev(6'h20);
        chk("run", 8'h00, 8'(gesture_run));
        host.acc(1, 0, gesture_fifo_pkg::ADDR_STATE_FLAGS, 0, d);
        chk("valid", 8'h00, d & 8'h01);
        ev(6'h08);
        chk("run", 8'h01, 8'(gesture_run));
        ev(6'h30);
        chk("run", 8'h00, 8'(gesture_run));
        for (int k = 0; k < 3; k++) begin
            ev(6'h01 << k);
            chk("irq", 8'h01, 8'(irq_out));
            host.acc(k[0], ~k[0], 8'hE3 + 8'(k + (k > 0)), 0, d);
            chk("irq", 8'h00, 8'(irq_out));
        end
        ev(6'h07);
        host.acc(1, 0, gesture_fifo_pkg::ADDR_ALL_CLEAR, 0, d);
        chk("irq", 8'h00, 8'(irq_out));
        host.acc(0, 1, gesture_fifo_pkg::ADDR_IRQ_FORCE, 0, d);
        chk("irq", 8'h01, 8'(irq_out));
        summarize();
    end
endmodule : gesture_fifo_control_bench
`default_nettype wire
